// ### verilog/hrp_map.vh
`ifndef HRP_MAP_VH
`define HRP_MAP_VH
// Bus style codes
`define HRP_STYLE_ASYNC_A   3'h0
`define HRP_STYLE_ASYNC_B   3'h1
`define HRP_STYLE_SYNC      3'h7
// Chip select decode
`define HRP_CS_SELF         3'h0
`define HRP_CS_RSVD         3'h6
`define HRP_CS_ALL          3'h7
`define HRP_CS_COUNT        6
// Register offsets
`define HRP_REG_DRV_ON      8'h00
`define HRP_REG_RX_TERM     8'h01
`define HRP_REG_STATUS      8'h02
`define HRP_REG_IRQ_MASK    8'h03
`define HRP_REG_IRQ_STAT    8'h04
`define HRP_REG_SCRATCH     8'h05
// Reset values
`define HRP_RST_DRV_ON      8'hff
`define HRP_RST_RX_TERM     8'h00
`define HRP_RST_MASK        8'h00
`define HRP_RST_BYTE        8'h00
// Access states
`define HRP_ST_IDLE         2'h0
`define HRP_ST_ACT          2'h1
`define HRP_ST_DONE         2'h2
`endif

// ### verilog/hrp_host_register_port.v
// Function
// - Bus style picked by select pins: 000, 001 asynchronous, 111 synchronous.
// - Eight-bit two-way data bus, device drives on reads, processor on writes.
// - Top three address bits drive companion chip-select decoder, not registers.
// - Low eight address bits select one register directly, no paging.
// - Read and write strobes ignored while active-low select is high.
// - Software writes configuration registers and reads monitoring registers.
// - Status readable by polling, and also signalled by interrupt output.
// - Low line-driver-on bit switches that channel's transmitter off.
// - Asynchronous styles latch low address on falling edge of address strobe.
// - Active-low done output goes low when access completes.
`timescale 1ns/1ps
`default_nettype none
`include "hrp_map.vh"

// ****************************************
// Operating notes
// ****************************************
// The style straps are static; changing them mid-access gives an undefined cycle.
// Style codes other than the three decoded ones fall back to separate strobes.
// Async styles follow the low address while the latch strobe is high.
// The low address is then held from the strobe's fall until the next strobe.
// Tie the latch strobe high to make the async styles follow the address pins.
// The synchronous style always uses the address pins directly.
// An access is taken in idle, runs one cycle, then waits in done.
// Done stays low until the strobe is released, so the host sees a full handshake.
// Read data is registered and held for the whole done phase.
// The bus output enable is low only while a selected read is being answered.
// Unmapped addresses read back zero and ignore writes.
// Status bits are sticky on a rising channel status edge.
// Writing ones to the sticky register clears it, but a new edge in the same
// cycle wins, so no rising status edge is ever lost.
// The interrupt output is the masked sticky status, registered.
// Companion selects follow the select and upper address one cycle late.
// The receiver termination order during card swaps is up to software:
// terminate the backup receivers first, then float the primary ones.
// A low line-driver-on bit turns that channel's transmitter off.
// All outputs come straight from flip-flops to keep the pins glitch free.

module hrp_host_register_port #(
    parameter CHANNELS = 8
) (
    input  wire                clk,
    input  wire                sys_rst,
    input  wire [2:0]          bus_style_select,
    input  wire [10:0]         addr,
    input  wire                addr_strobe,
    input  wire                rd_n,
    input  wire                wr_n,
    input  wire                sel_n,
    input  wire [7:0]          data_in,
    output reg  [7:0]          data_out,
    output reg  [7:0]          data_oe_n,
    output reg                 done_n,
    output reg  [`HRP_CS_COUNT-2:0] comp_cs_n,
    output reg  [CHANNELS-1:0] line_driver_on,
    output reg  [CHANNELS-1:0] rx_internal_term,
    output reg                 irq_n,
    input  wire [7:0]          chan_status
);

    // ****************************************
    // Strobe decode per bus style
    // ****************************************
    reg        ale_d;
    reg  [7:0] addr_lat;
    reg  [7:0] st_prev;
    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        acc_write;
    reg  [7:0] irq_mask;
    reg  [7:0] irq_stat;
    reg  [7:0] scratch;
    reg        req;
    reg        req_wr;
    wire       style_async = (bus_style_select == `HRP_STYLE_ASYNC_A) ||
                             (bus_style_select == `HRP_STYLE_ASYNC_B);
    wire       style_b     = (bus_style_select == `HRP_STYLE_ASYNC_B) ||
                             (bus_style_select == `HRP_STYLE_SYNC);
    wire [7:0] eff_addr    = style_async ? addr_lat : addr[7:0];
    wire [7:0] stat_rise   = chan_status & ~st_prev;

    // Request decode: style A uses separate strobes, B and sync use enable plus direction
    always @* begin
        req    = 1'b0;
        req_wr = 1'b0;
        if (!sel_n) begin
            if (style_b) begin
                req    = !rd_n;
                req_wr = !wr_n;
            end else begin
                req    = !rd_n || !wr_n;
                req_wr = !wr_n;
            end
        end
    end

    // Register read mux
    function [7:0] hrp_read;
        input [7:0] a;
        begin
            case (a)
                `HRP_REG_DRV_ON:   hrp_read = line_driver_on;
                `HRP_REG_RX_TERM:  hrp_read = rx_internal_term;
                `HRP_REG_STATUS:   hrp_read = chan_status;
                `HRP_REG_IRQ_MASK: hrp_read = irq_mask;
                `HRP_REG_IRQ_STAT: hrp_read = irq_stat;
                `HRP_REG_SCRATCH:  hrp_read = scratch;
                default:           hrp_read = `HRP_RST_BYTE;
            endcase
        end
    endfunction

    // ****************************************
    // Address latch
    // ****************************************
    // Capture low address on falling edge of the address strobe
    always @(posedge clk) begin
        if (sys_rst) begin
            ale_d    <= 1'b0;
            addr_lat <= `HRP_RST_BYTE;
        end else begin
            ale_d <= addr_strobe;
            if (addr_strobe)
                addr_lat <= addr[7:0];
            else if (ale_d && !sel_n)
                addr_lat <= addr_lat;
        end
    end

    // ****************************************
    // Access state machine
    // ****************************************
    always @* begin
        case (state)
            `HRP_ST_IDLE: next_state = req ? `HRP_ST_ACT : `HRP_ST_IDLE;
            `HRP_ST_ACT:  next_state = `HRP_ST_DONE;
            `HRP_ST_DONE: next_state = req ? `HRP_ST_DONE : `HRP_ST_IDLE;
            default:      next_state = `HRP_ST_IDLE;
        endcase
    end

    // Sequencing, register writes and bus drive
    always @(posedge clk) begin
        if (sys_rst) begin
            state            <= `HRP_ST_IDLE;
            acc_write        <= 1'b0;
            done_n           <= 1'b1;
            data_out         <= `HRP_RST_BYTE;
            data_oe_n        <= 8'hff;
            line_driver_on   <= {CHANNELS{1'b1}};
            rx_internal_term <= {CHANNELS{1'b0}};
            irq_mask         <= `HRP_RST_MASK;
            irq_stat         <= `HRP_RST_BYTE;
            scratch          <= `HRP_RST_BYTE;
            st_prev          <= `HRP_RST_BYTE;
            irq_n            <= 1'b1;
        end else begin
            state   <= next_state;
            st_prev <= chan_status;
            if (state == `HRP_ST_IDLE && req)
                acc_write <= req_wr;
            done_n <= !(next_state == `HRP_ST_DONE);
            // Write decode, one register per address
            if (state == `HRP_ST_ACT && acc_write) begin
                case (eff_addr)
                    `HRP_REG_DRV_ON:   line_driver_on   <= data_in[CHANNELS-1:0];
                    `HRP_REG_RX_TERM:  rx_internal_term <= data_in[CHANNELS-1:0];
                    `HRP_REG_IRQ_MASK: irq_mask         <= data_in;
                    `HRP_REG_SCRATCH:  scratch          <= data_in;
                    default:           ;
                endcase
            end
            // Sticky status: set wins over write-one-to-clear
            if (state == `HRP_ST_ACT && acc_write && eff_addr == `HRP_REG_IRQ_STAT)
                irq_stat <= (irq_stat & ~data_in) | stat_rise;
            else
                irq_stat <= irq_stat | stat_rise;
            irq_n <= ~|((irq_stat | stat_rise) & irq_mask);
            // Drive data only during a selected read
            if (state == `HRP_ST_ACT && !acc_write && !sel_n) begin
                data_out  <= hrp_read(eff_addr);
                data_oe_n <= 8'h00;
            end else if (!(state == `HRP_ST_DONE && !acc_write && req)) begin
                data_oe_n <= 8'hff;
            end
        end
    end

    // ****************************************
    // Companion chip-select decoder
    // ****************************************
    wire [`HRP_CS_COUNT-2:0] next_cs_n;
    genvar gi;
    generate
        for (gi = 0; gi < `HRP_CS_COUNT - 1; gi = gi + 1) begin : g_cs
            // Chip gi+1 selected by its code or by the all-devices code
            assign next_cs_n[gi] = !(!sel_n && (addr[10:8] == gi + 1 ||
                                     addr[10:8] == `HRP_CS_ALL));
        end
    endgenerate

    // One register for all selects, so each pin has a single driver
    always @(posedge clk) begin
        if (sys_rst)
            comp_cs_n <= {(`HRP_CS_COUNT-1){1'b1}};
        else
            comp_cs_n <= next_cs_n;
    end

endmodule
`default_nettype wire

// ### sim/hrp_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host port checks
// ****************
module hrp_props #(
    parameter CHANNELS = 8
) (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic [10:0]         addr,
    input wire logic                rd_n,
    input wire logic                wr_n,
    input wire logic                sel_n,
    input wire logic [7:0]          data_oe_n,
    input wire logic                done_n,
    input wire logic [4:0]          comp_cs_n,
    input wire logic [CHANNELS-1:0] line_driver_on,
    input wire logic [CHANNELS-1:0] rx_internal_term
);
    default clocking @(posedge clk); endclocking
    logic [4:0] cs_exp;
    // Expected companion selects; codes 0 and 6 select no companion
    always_comb cs_exp = addr[10:8] == 3'h7 ? 5'h00 : ~(5'h01 << (addr[10:8] - 3'h1));
    rst_vals_a: assert property (sys_rst |=> &line_driver_on && rx_internal_term == 0 && done_n)
        else $error("reset outputs wrong");
    oe_read_a: assert property (disable iff (sys_rst) !data_oe_n[0] |-> $past(!rd_n && wr_n && !sel_n))
        else $error("bus driven outside read");
    oe_whole_a: assert property (data_oe_n == 8'h00 || data_oe_n == 8'hff)
        else $error("partial bus drive");
    sel_gate_a: assert property (disable iff (sys_rst) sel_n [*3] |=> done_n)
        else $error("access while deselected");
    done_low_a: assert property (disable iff (sys_rst) $fell(rd_n) && !sel_n && done_n |-> ##[1:3] !done_n)
        else $error("done missing");
    done_rel_a: assert property (disable iff (sys_rst) !done_n && rd_n && wr_n |=> done_n)
        else $error("done stuck low");
    cs_dec_a: assert property (disable iff (sys_rst) !sel_n |=> comp_cs_n == $past(cs_exp))
        else $error("chip select decode wrong");
    cfg_wr_a: assert property (disable iff (sys_rst) !$past(sys_rst) && $changed({line_driver_on, rx_internal_term}) |-> $past(!wr_n && !sel_n))
        else $error("config changed without write");
    cover property (!done_n && !data_oe_n[0]);
    cover property (!done_n && !wr_n);
    cover property (comp_cs_n == 5'h00);
endmodule
bind hrp_host_register_port hrp_props #(.CHANNELS(CHANNELS)) u_props (.clk(clk), .sys_rst(sys_rst),
    .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .sel_n(sel_n), .data_oe_n(data_oe_n), .done_n(done_n),
    .comp_cs_n(comp_cs_n), .line_driver_on(line_driver_on), .rx_internal_term(rx_internal_term));
`default_nettype wire

// ### sim/hrp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// *******************
// Processor bus model
// *******************
module hrp_cpu_model (
    input  wire logic        clk,
    input  wire logic [2:0]  sty,
    input  wire logic        done_n,
    input  wire logic [7:0]  data_out,
    input  wire logic [7:0]  data_oe_n,
    output var  logic [10:0] addr,
    output var  logic        ale,
    output var  logic        rd_n,
    output var  logic        wr_n,
    output var  logic        sel_n,
    output wire logic [7:0]  data_in
);
    logic       drv = 0;
    logic [7:0] wd = 8'h00;
    // Undriven bus shows the inverse of the device's value
    assign data_in = drv ? wd : ~data_out;
    initial {addr, ale, rd_n, wr_n, sel_n} = {11'h000, 4'h7};
    // One access; strobes held until done is seen or eight cycles have passed
    task automatic access(input logic s, input logic w, input logic [10:0] a, input logic [7:0] d,
                          output logic [7:0] r);
        int n;
        @(negedge clk);
        {addr, sel_n, ale, drv, wd} = {a, s, 1'b1, w, d};
        wr_n = !(w && sty != 3'h0);
        @(negedge clk);
        ale = 0;
        @(negedge clk);
        if (sty != 3'h7) addr[7:0] = ~a[7:0];
        rd_n = w && sty == 3'h0;
        wr_n = !w;
        for (n = 0; n < 8 && done_n !== 1'b0; n++) @(negedge clk);
        r = data_oe_n === 8'h00 ? data_out : ~data_out;
        {rd_n, wr_n} = 2'b11;
        @(negedge clk);
        {sel_n, drv} = 2'b10;
    endtask
endmodule
`default_nettype wire

// ### sim/hrp_host_register_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ***************
// Host port bench
// ***************
module hrp_host_register_port_tb;
    typedef struct {logic w; logic [10:0] a; logic [7:0] d; logic [7:0] e;} hrp_row;
    hrp_row rows [8] = '{'{1, 11'h300, 8'h5a, 8'h5a}, '{0, 11'h700, 8'h00, 8'h5a},
        '{1, 11'h105, 8'ha5, 8'h00}, '{0, 11'h605, 8'h00, 8'ha5}, '{1, 11'h001, 8'h3c, 8'h3c},
        '{0, 11'h201, 8'h00, 8'h3c}, '{1, 11'h040, 8'hff, 8'h5a}, '{0, 11'h540, 8'h00, 8'h00}};
    logic        clk = 0, sys_rst = 1, ale, rd_n, wr_n, sel_n, done_n, irq_n;
    logic [2:0]  sty = 3'h0;
    logic [7:0]  cst = 8'h00, data_in, data_out, oe_n, ldo, rxt, r;
    logic [10:0] addr;
    logic [4:0]  cs_n;
    // Expected companion selects for each row's upper address code
    logic [4:0]  cse [8] = '{5'h1b, 5'h00, 5'h1e, 5'h1f, 5'h1f, 5'h1d, 5'h1f, 5'h0f};
    int          err_total = 0, n_compared = 0, cyc = 0, i, s;
    hrp_host_register_port dut (.clk(clk), .sys_rst(sys_rst), .bus_style_select(sty), .addr(addr),
        .addr_strobe(ale), .rd_n(rd_n), .wr_n(wr_n), .sel_n(sel_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(oe_n), .done_n(done_n), .comp_cs_n(cs_n), .line_driver_on(ldo), .rx_internal_term(rxt),
        .irq_n(irq_n), .chan_status(cst));
    hrp_cpu_model cpu (.clk(clk), .sty(sty), .done_n(done_n), .data_out(data_out), .data_oe_n(oe_n),
        .addr(addr), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .sel_n(sel_n), .data_in(data_in));
    // Clock and hang guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Table rows in every bus style, then hand-written cases
    initial begin
        for (s = 0; s < 3; s++) begin
            sty = s == 0 ? 3'h0 : s == 1 ? 3'h1 : 3'h7;
            sys_rst = 1;
            repeat (5) @(negedge clk);
            sys_rst = 0;
            chk(ldo, 8'hff);
            for (i = 0; i < 8; i++) begin
                cpu.access(1'b0, rows[i].w, rows[i].a, rows[i].d, r);
                chk(rows[i].w ? (rows[i].a[0] ? rxt : ldo) : r, rows[i].e);
                chk({3'h0, cs_n}, {3'h0, cse[i]});
                chk(oe_n, 8'hff);
                chk({7'h00, done_n}, 8'h01);
            end
            $display("style %0d done", sty);
        end
        cpu.access(1'b1, 1'b1, 11'h000, 8'h11, r);
        chk(ldo, 8'h5a);
        chk({3'h0, cs_n}, 8'h1f);
        cpu.access(1'b0, 1'b1, 11'h000, 8'h00, r);
        chk(ldo, 8'h00);
        cpu.access(1'b0, 1'b1, 11'h001, 8'hff, r);
        chk(rxt, 8'hff);
        cpu.access(1'b0, 1'b1, 11'h001, 8'h00, r);
        chk(rxt, 8'h00);
        cst = 8'h81;
        cpu.access(1'b0, 1'b0, 11'h002, 8'h00, r);
        chk(r, 8'h81);
        cpu.access(1'b0, 1'b0, 11'h004, 8'h00, r);
        chk(r, 8'h81);
        chk({7'h00, irq_n}, 8'h01);
        cpu.access(1'b0, 1'b1, 11'h003, 8'h01, r);
        chk({7'h00, irq_n}, 8'h00);
        cpu.access(1'b0, 1'b1, 11'h004, 8'hff, r);
        cpu.access(1'b0, 1'b0, 11'h004, 8'h00, r);
        chk(r, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        $display("hand tests done");
        report_and_stop;
    end
endmodule
`default_nettype wire
